//--- upd_pin_ctrl.v
`timescale 1ns/1ns
// How it works
// - Optional receive inversion before infrared decoder.
// - Modem control bit 6 selects infrared path.
// - Clear-to-send gates transmit; interrupt enable bit 7.
// - Set-ready, carrier, ring only general inputs.
// - Modem bit 3 drives output2 low, enables interrupt.
// - Shared low input forces half-duplex direction.
// - Direction mode: low transmitting, high receiving.
// - Shared input ORed with feature control bit 3.
`include "upd_pin_map.vh"

module upd_pin_ctrl
(
  input wire clock,
  input wire reset,
  // Register port
  input wire [`UPD_ADDR_W-1:0] reg_addr,
  input wire [`UPD_DATA_W-1:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [`UPD_DATA_W-1:0] reg_rdata,
  // Pins
  input wire chan_b_serial_in,
  input wire chan_b_clear_to_send_n,
  input wire chan_b_set_ready_n,
  input wire chan_b_carrier_detect_n,
  input wire chan_b_ring_indicator_n,
  input wire half_duplex_dir_select_n,
  output reg chan_b_request_to_send_n,
  output reg chan_b_terminal_ready_n,
  output reg chan_b_gp_output2_n,
  output reg chan_b_interrupt_out,
  output reg chan_b_interrupt_oe,
  // Datapath side, same clock
  input wire tx_shift_busy,
  input wire rx_flow_stop,
  output reg uart_rx_serial,
  output reg ir_decoder_in,
  output reg ir_mode_sel,
  output reg tx_start_allowed,
  output reg irq
);

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  reg [`UPD_DATA_W-1:0] ier_ff;
  reg [`UPD_DATA_W-1:0] efr_ff;
  reg [`UPD_DATA_W-1:0] mcr_ff;
  reg [`UPD_DATA_W-1:0] feature_control_reg_ff;
  reg [`UPD_DATA_W-1:0] status_ff;
  reg [`UPD_DATA_W-1:0] mask_ff;
  reg [`UPD_DATA_W-1:0] nxt_status;
  reg [`UPD_DATA_W-1:0] nxt_rdata;
  reg [`UPD_DATA_W-1:0] ev_set;
  reg [`UPD_SY_W-1:0] prev_ff;
  reg dir_prev_ff;
  reg nxt_rts_n;
  reg nxt_rx;
  wire [`UPD_SY_W-1:0] pin_sync;
  wire dir_mode;
  wire any_int;

  // Write decode shared by every control register
  function wr_hit;
    input [`UPD_ADDR_W-1:0] addr;
    input [`UPD_ADDR_W-1:0] target;
    input we;
    begin
      wr_hit = we && (addr == target);
    end
  endfunction

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  upd_sync
  #(
    .WIDTH(`UPD_SY_W),
    .RESET_VAL(`UPD_RST_SYNC)
  )
  u_sync
  (
    .clock(clock),
    .reset(reset),
    .async_in({half_duplex_dir_select_n, chan_b_ring_indicator_n,
      chan_b_carrier_detect_n, chan_b_set_ready_n,
      chan_b_clear_to_send_n, chan_b_serial_in}),
    .sync_out(pin_sync)
  );

  // Direction mode: shared pin low or feature bit set
  assign dir_mode = ~pin_sync[`UPD_SY_HD] | feature_control_reg_ff[`UPD_FEATURE_CONTROL_REG_DIR];

  // ----------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------
  // Software writes steer pins and flow control
  always @(posedge clock)
  begin
    if (reset)
    begin
      ier_ff <= `UPD_RST_REG;
      efr_ff <= `UPD_RST_REG;
      mcr_ff <= `UPD_RST_REG;
      feature_control_reg_ff <= `UPD_RST_REG;
      mask_ff <= `UPD_RST_REG;
    end
    else
    begin
      if (wr_hit(reg_addr, `UPD_ADDR_IER, reg_write))
        ier_ff <= reg_wdata;
      if (wr_hit(reg_addr, `UPD_ADDR_EFR, reg_write))
        efr_ff <= reg_wdata;
      if (wr_hit(reg_addr, `UPD_ADDR_MCR, reg_write))
        mcr_ff <= reg_wdata;
      if (wr_hit(reg_addr, `UPD_ADDR_FEATURE_CONTROL_REG, reg_write))
        feature_control_reg_ff <= reg_wdata;
      if (wr_hit(reg_addr, `UPD_ADDR_MASK, reg_write))
        mask_ff <= reg_wdata;
    end
  end

  // ----------------------------------------------------------
  // Events and sticky status
  // ----------------------------------------------------------
  // Pin changes only raise status, ring indicator on its rising edge only; never touch the datapath
  always @*
  begin
    ev_set = `UPD_RST_REG;
    ev_set[`UPD_ST_CTS] = pin_sync[`UPD_SY_CTS] ^ prev_ff[`UPD_SY_CTS];
    ev_set[`UPD_ST_DSR] = pin_sync[`UPD_SY_DSR] ^ prev_ff[`UPD_SY_DSR];
    ev_set[`UPD_ST_CD] = pin_sync[`UPD_SY_CD] ^ prev_ff[`UPD_SY_CD];
    ev_set[`UPD_ST_RI] = pin_sync[`UPD_SY_RI] & ~prev_ff[`UPD_SY_RI];
    ev_set[`UPD_ST_DIR] = dir_mode ^ dir_prev_ff;
  end

  // Read of status clears it; a new event in the same cycle wins
  always @*
  begin
    nxt_status = status_ff;
    if (reg_read && (reg_addr == `UPD_ADDR_STAT))
      nxt_status = `UPD_RST_REG;
    nxt_status = nxt_status | ev_set;
  end

  // Clear-to-send change only interrupts when its enable is set
  assign any_int = |(status_ff & mask_ff & {{(`UPD_DATA_W-1){1'b1}},
    ier_ff[`UPD_IER_CTS_INT]});

  // History of pins for edge detection
  always @(posedge clock)
  begin
    if (reset)
    begin
      status_ff <= `UPD_RST_REG;
      prev_ff <= `UPD_RST_SYNC;
      dir_prev_ff <= 1'b0;
    end
    else
    begin
      status_ff <= nxt_status;
      prev_ff <= pin_sync;
      dir_prev_ff <= dir_mode;
    end
  end

  // ----------------------------------------------------------
  // Request-to-send and receive path selection
  // ----------------------------------------------------------
  always @*
  begin
    if (dir_mode)
      nxt_rts_n = ~tx_shift_busy;
    else if (efr_ff[`UPD_EFR_AUTO_RTS] && mcr_ff[`UPD_MCR_RTS])
      nxt_rts_n = rx_flow_stop;
    else
      nxt_rts_n = ~mcr_ff[`UPD_MCR_RTS];
  end

  // Infrared input may be inverted before the decoder
  always @*
  begin
    nxt_rx = pin_sync[`UPD_SY_RX];
    if (mcr_ff[`UPD_MCR_IR] && feature_control_reg_ff[`UPD_FEATURE_CONTROL_REG_IR_INV])
      nxt_rx = ~pin_sync[`UPD_SY_RX];
  end

  // ----------------------------------------------------------
  // Read data
  // ----------------------------------------------------------
  always @*
  begin
    nxt_rdata = `UPD_RST_REG;
    if (reg_read)
    begin
      case (reg_addr)
        `UPD_ADDR_IER: nxt_rdata = ier_ff;
        `UPD_ADDR_EFR: nxt_rdata = efr_ff;
        `UPD_ADDR_MCR: nxt_rdata = mcr_ff;
        `UPD_ADDR_FEATURE_CONTROL_REG: nxt_rdata = feature_control_reg_ff;
        `UPD_ADDR_STAT: nxt_rdata = status_ff;
        `UPD_ADDR_MASK: nxt_rdata = mask_ff;
        `UPD_ADDR_PINS:
        begin
          nxt_rdata[`UPD_ST_CTS] = ~pin_sync[`UPD_SY_CTS];
          nxt_rdata[`UPD_ST_DSR] = ~pin_sync[`UPD_SY_DSR];
          nxt_rdata[`UPD_ST_CD] = ~pin_sync[`UPD_SY_CD];
          nxt_rdata[`UPD_ST_RI] = ~pin_sync[`UPD_SY_RI];
          nxt_rdata[`UPD_ST_DIR] = dir_mode;
        end
        default: nxt_rdata = `UPD_RST_REG;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Register port read data
  // ----------------------------------------------------------
  // Read data stand for one cycle and fall back to zero
  always @(posedge clock)
  begin
    if (reset)
      reg_rdata <= `UPD_RST_REG;
    else
      reg_rdata <= nxt_rdata;
  end

  // ----------------------------------------------------------
  // Modem control outputs
  // ----------------------------------------------------------
  // Request-to-send and terminal-ready rest inactive high
  always @(posedge clock)
  begin
    if (reset)
    begin
      chan_b_request_to_send_n <= 1'b1;
      chan_b_terminal_ready_n <= 1'b1;
    end
    else
    begin
      chan_b_request_to_send_n <= nxt_rts_n;
      chan_b_terminal_ready_n <= ~mcr_ff[`UPD_MCR_DTR];
    end
  end

  // Output2 and interrupt pin share one control bit
  always @(posedge clock)
  begin
    if (reset)
    begin
      chan_b_gp_output2_n <= 1'b1;
      chan_b_interrupt_oe <= 1'b0;
      chan_b_interrupt_out <= 1'b0;
    end
    else
    begin
      chan_b_gp_output2_n <= ~mcr_ff[`UPD_MCR_OP2];
      chan_b_interrupt_oe <= mcr_ff[`UPD_MCR_OP2];
      chan_b_interrupt_out <= any_int & mcr_ff[`UPD_MCR_OP2];
    end
  end

  // ----------------------------------------------------------
  // Receive path selection
  // ----------------------------------------------------------
  // Only the selected path sees the pin; the other rests at idle
  always @(posedge clock)
  begin
    if (reset)
    begin
      ir_mode_sel <= 1'b0;
      uart_rx_serial <= 1'b1;
      ir_decoder_in <= 1'b0;
    end
    else
    begin
      ir_mode_sel <= mcr_ff[`UPD_MCR_IR];
      // Normal path idles high; held high in infrared mode
      uart_rx_serial <= mcr_ff[`UPD_MCR_IR] | pin_sync[`UPD_SY_RX];
      // Decoder idles low; held low in normal mode
      ir_decoder_in <= mcr_ff[`UPD_MCR_IR] & nxt_rx;
    end
  end

  // ----------------------------------------------------------
  // Transmit gating and interrupt request
  // ----------------------------------------------------------
  // Clear-to-send high stops new characters only with auto flow on
  always @(posedge clock)
  begin
    if (reset)
    begin
      tx_start_allowed <= 1'b1;
      irq <= 1'b0;
    end
    else
    begin
      tx_start_allowed <= ~efr_ff[`UPD_EFR_AUTO_CTS] | ~pin_sync[`UPD_SY_CTS];
      irq <= any_int;
    end
  end

endmodule

//--- upd_pin_map.vh
`ifndef UPD_PIN_MAP_VH
`define UPD_PIN_MAP_VH

// ------------------------------------------------------------
// Register offsets on the 4-bit register port
// ------------------------------------------------------------
`define UPD_ADDR_W 4
`define UPD_DATA_W 8
`define UPD_ADDR_IER 4'h1
`define UPD_ADDR_EFR 4'h2
`define UPD_ADDR_MCR 4'h4
`define UPD_ADDR_PINS 4'h6
`define UPD_ADDR_FEATURE_CONTROL_REG 4'h8
`define UPD_ADDR_STAT 4'h9
`define UPD_ADDR_MASK 4'ha

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define UPD_MCR_DTR 0
`define UPD_MCR_RTS 1
`define UPD_MCR_OP2 3
`define UPD_MCR_IR 6
`define UPD_FEATURE_CONTROL_REG_IR_INV 2
`define UPD_FEATURE_CONTROL_REG_DIR 3
`define UPD_EFR_AUTO_RTS 6
`define UPD_EFR_AUTO_CTS 7
`define UPD_IER_CTS_INT 7

// Sticky status bits, mask uses the same layout
`define UPD_ST_CTS 0
`define UPD_ST_DSR 1
`define UPD_ST_CD 2
`define UPD_ST_RI 3
`define UPD_ST_DIR 4

// Synchroniser lanes
`define UPD_SY_RX 0
`define UPD_SY_CTS 1
`define UPD_SY_DSR 2
`define UPD_SY_CD 3
`define UPD_SY_RI 4
`define UPD_SY_HD 5
`define UPD_SY_W 6

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define UPD_RST_REG 8'h00
`define UPD_RST_SYNC 6'h3f

`endif

//--- upd_sync.v
`timescale 1ns/1ns
// Two-flop synchroniser bank for asynchronous pin inputs
module upd_sync
#(
  parameter WIDTH = 6,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
)
(
  input wire clock,
  input wire reset,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1_ff;
  reg [WIDTH-1:0] stage2_ff;

  // First stage is read only by the second stage
  always @(posedge clock)
  begin
    if (reset)
    begin
      stage1_ff <= RESET_VAL;
      stage2_ff <= RESET_VAL;
    end
    else
    begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out = stage2_ff;

endmodule

//--- upd_line_model.sv
`timescale 1ns/1ns
// Far-end transceiver: receive line and clear-to-send one cycle behind command, general status lines direct
module upd_line_model
(
  input wire clock,
  input wire line_low,
  input wire cts_off,
  input wire [2:0] gp_n,
  output reg chan_b_serial_in = 1'b1,
  output reg chan_b_clear_to_send_n = 1'b0,
  output wire chan_b_set_ready_n,
  output wire chan_b_carrier_detect_n,
  output wire chan_b_ring_indicator_n
);
  // Receive line idles high unless a low level is commanded
  always @(posedge clock)
  begin
    chan_b_serial_in <= !line_low;
    chan_b_clear_to_send_n <= cts_off;
  end
  // General inputs straight from the command
  assign {chan_b_ring_indicator_n, chan_b_carrier_detect_n, chan_b_set_ready_n} = gp_n;
endmodule

//--- upd_pin_ctrl_properties.sv
`timescale 1ns/1ns
module upd_pin_props
(
  input logic clock,
  input logic reset,
  input logic [3:0] reg_addr,
  input logic reg_write,
  input logic reg_read,
  input logic [7:0] reg_rdata,
  input logic chan_b_serial_in,
  input logic chan_b_clear_to_send_n,
  input logic half_duplex_dir_select_n,
  input logic chan_b_request_to_send_n,
  input logic chan_b_terminal_ready_n,
  input logic chan_b_gp_output2_n,
  input logic chan_b_interrupt_out,
  input logic chan_b_interrupt_oe,
  input logic tx_shift_busy,
  input logic uart_rx_serial,
  input logic ir_decoder_in,
  input logic ir_mode_sel,
  input logic tx_start_allowed,
  input logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Pin relations
  a_op2_oe_pair: assert property (chan_b_gp_output2_n == !chan_b_interrupt_oe)
    else $error("output2 and interrupt enable disagree");
  a_int_gated: assert property (!chan_b_interrupt_oe |-> !chan_b_interrupt_out)
    else $error("interrupt pin active while tri-stated");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_dir_rts: assert property ((!half_duplex_dir_select_n)[*4] |=>
    chan_b_request_to_send_n == !$past(tx_shift_busy))
    else $error("direction output does not follow transmit");
  a_ir_idle: assert property (ir_mode_sel ? uart_rx_serial : !ir_decoder_in)
    else $error("unused receive path not idle");
  a_rx_path: assert property ((!ir_mode_sel)[*4] |->
    uart_rx_serial == $past(chan_b_serial_in, 3))
    else $error("normal receive path wrong");
  a_cts_cause: assert property (!tx_start_allowed |-> $past(chan_b_clear_to_send_n, 3))
    else $error("transmit stopped without clear-to-send high");
  a_out_by_write: assert property ($changed({chan_b_terminal_ready_n, ir_mode_sel}) |->
    $past(reg_write, 2) && $past(reg_addr, 2) == 4'h4)
    else $error("modem output changed without a write");
  c_read: cover property (reg_read ##1 reg_rdata != 8'h00);
  c_stop: cover property (!tx_start_allowed);
  c_irq: cover property (irq ##1 !irq);
endmodule
bind upd_pin_ctrl upd_pin_props chk_u (.*);

//--- uart_modem_pins_rs485_direction_bench.sv
`timescale 1ns/1ns
`include "upd_pin_map.vh"
module uart_modem_pins_rs485_direction_bench;
  reg clock = 1'b0;
  reg reset = 1'b1;
  reg [3:0] reg_addr = 4'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_write = 1'b0;
  reg reg_read = 1'b0;
  reg half_duplex_dir_select_n = 1'b1;
  reg tx_shift_busy = 1'b0;
  reg rx_flow_stop = 1'b0;
  reg line_low = 1'b0;
  reg cts_off = 1'b0;
  reg [2:0] gp_n = 3'h7;
  reg rd_d = 1'b0;
  reg [2:0] rnd;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [7:0] exp_q[$];
  wire [7:0] reg_rdata;
  wire chan_b_serial_in, chan_b_clear_to_send_n, chan_b_set_ready_n, chan_b_carrier_detect_n;
  wire chan_b_ring_indicator_n, chan_b_request_to_send_n, chan_b_terminal_ready_n;
  wire chan_b_gp_output2_n, chan_b_interrupt_out, chan_b_interrupt_oe;
  wire uart_rx_serial, ir_decoder_in, ir_mode_sel, tx_start_allowed, irq;
  upd_line_model line_u (.*);
  upd_pin_ctrl dut_u (.*);
  // Free-running clock
  always #5 clock = ~clock;
  task chk(input logic [7:0] got, input logic [7:0] exp);
  begin
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
  begin
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    wt(2);
  end
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
  begin
    exp_q.push_back(e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    wt(2);
  end
  endtask
  task close_out;
  begin
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  // Read data is compared with the oldest note
  always @(posedge clock)
  begin
    rd_d <= reg_read;
    if (rd_d)
      chk(reg_rdata, exp_q.pop_front());
  end
  // Cut a hang short
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      close_out();
    end
  end
  // Main sequence
  initial
  begin
    void'($urandom(32'h659c));
    wt(10);
    reset <= 1'b0;
    wt(2);
    chk({chan_b_request_to_send_n, chan_b_gp_output2_n, chan_b_interrupt_oe, irq,
      tx_start_allowed, uart_rx_serial, ir_decoder_in, ir_mode_sel}, 8'hcc);
    rd(4'hf, 8'h00);
    wr(`UPD_ADDR_MASK, 8'h01);
    wr(`UPD_ADDR_MCR, 8'h09);
    chk({chan_b_gp_output2_n, chan_b_interrupt_oe, chan_b_terminal_ready_n}, 8'h02);
    wr(`UPD_ADDR_IER, 8'h80);
    wr(`UPD_ADDR_EFR, 8'h80);
    cts_off <= 1'b1;
    wt(6);
    chk({tx_start_allowed, irq, chan_b_interrupt_out}, 8'h03);
    rd(`UPD_ADDR_STAT, 8'h01);
    chk({irq, chan_b_interrupt_out}, 8'h00);
    wr(`UPD_ADDR_MASK, 8'h00);
    cts_off <= 1'b0;
    wt(6);
    chk({tx_start_allowed, irq}, 8'h02);
    rd(`UPD_ADDR_STAT, 8'h01);
    rnd = $urandom % 8;
    gp_n <= rnd;
    wt(6);
    chk(tx_start_allowed, 8'h01);
    rd(`UPD_ADDR_PINS, {3'h0, 1'b0, ~rnd, 1'b1});
    wr(`UPD_ADDR_FEATURE_CONTROL_REG, 8'h04);
    wr(`UPD_ADDR_MCR, 8'h40);
    line_low <= 1'b1;
    wt(6);
    chk({ir_mode_sel, uart_rx_serial, ir_decoder_in}, 8'h07);
    chk({chan_b_gp_output2_n, chan_b_interrupt_out}, 8'h02);
    wr(`UPD_ADDR_FEATURE_CONTROL_REG, 8'h00);
    chk({ir_mode_sel, ir_decoder_in}, 8'h02);
    wr(`UPD_ADDR_MCR, 8'h00);
    wt(4);
    chk({ir_mode_sel, uart_rx_serial, ir_decoder_in}, 8'h00);
    line_low <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      half_duplex_dir_select_n <= i[0];
      wr(`UPD_ADDR_FEATURE_CONTROL_REG, {4'h0, i[0], 3'h0});
      wt(5);
      tx_shift_busy <= 1'b1;
      wt(4);
      chk(chan_b_request_to_send_n, 8'h00);
      tx_shift_busy <= 1'b0;
      wt(2);
      chk(chan_b_request_to_send_n, 8'h01);
    end
    wr(`UPD_ADDR_FEATURE_CONTROL_REG, 8'h00);
    tx_shift_busy <= 1'b1;
    wt(3);
    chk(chan_b_request_to_send_n, 8'h01);
    wr(`UPD_ADDR_MCR, 8'h02);
    wr(`UPD_ADDR_EFR, 8'h40);
    rx_flow_stop <= 1'b1;
    wt(2);
    chk(chan_b_request_to_send_n, 8'h01);
    rx_flow_stop <= 1'b0;
    wt(2);
    chk(chan_b_request_to_send_n, 8'h00);
    wt(3);
    close_out();
  end
endmodule
